// File: paoc_defines.svh
// register offsets, field positions and reset values of the phase accumulator oscillator core
//
// Notes on behaviour
// - the accumulator is 20 bits over low, high and upper bytes, upper byte bits 7 to 4 read zero.
// - accumulator bytes read the live accumulator with no multi-byte snapshot.
// - the step is 20 bits over low, high and upper bytes, upper byte bits 7 to 4 read zero.
// - a hidden shadow step feeds the adder, refreshed on the first falling source edge after every second low step write, or at once while disabled.
// - on reset the step is 1 and every other step and accumulator byte is zero.
// - all accumulator and step bytes are readable and writable in their implemented bits.
// - each rising source edge while enabled adds the shadow step to the accumulator and a carry past 2^20 is a wrap.
// - in fixed duty mode the output toggles on each wrap.
// - in pulse frequency mode the output is active for 2^code source periods after each wrap.
// - each wrap sets the sticky interrupt flag which only software clears.
`ifndef PAOC_DEFINES_SVH
`define PAOC_DEFINES_SVH

// ==========================================================================
// register byte addresses
`define PAOC_ADDR_CTRL 8'h00
`define PAOC_ADDR_PULSE 8'h04
`define PAOC_ADDR_ACCL 8'h08
`define PAOC_ADDR_ACCH 8'h0C
`define PAOC_ADDR_ACCU 8'h10
`define PAOC_ADDR_INCL 8'h14
`define PAOC_ADDR_INCH 8'h18
`define PAOC_ADDR_INCU 8'h1C
`define PAOC_ADDR_STATUS 8'h20
`define PAOC_ADDR_MASK 8'h24

// ==========================================================================
// field positions
`define PAOC_CTRL_EN_BIT 7
`define PAOC_CTRL_OUT_BIT 5
`define PAOC_CTRL_POL_BIT 4
`define PAOC_CTRL_PFM_BIT 0
`define PAOC_PWS_MSB 7
`define PAOC_PWS_LSB 5
`define PAOC_WRAP_BIT 0

// ==========================================================================
// reset values
`define PAOC_STEP_RESET 20'h00001
`define PAOC_ACC_RESET 20'h00000

`endif

// File: paoc_pkg.sv
// types shared by the phase accumulator oscillator core
package paoc_pkg;
   // register selected by a bus address
   typedef enum logic [3:0] {
      PAOC_R_CTRL,
      PAOC_R_PULSE,
      PAOC_R_ACCL,
      PAOC_R_ACCH,
      PAOC_R_ACCU,
      PAOC_R_INCL,
      PAOC_R_INCH,
      PAOC_R_INCU,
      PAOC_R_STATUS,
      PAOC_R_MASK,
      PAOC_R_NONE
   } paoc_reg_t;
   typedef logic [19:0] paoc_word20_t;
endpackage

// File: paoc_core.sv
// phase accumulator oscillator core with an AHB-Lite register slave
`include "paoc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module paoc_core (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic osc_src_clock,
   output logic osc_out,
   output logic irq
);
   import paoc_pkg::*;

   // ========================================================================
   // state
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   paoc_reg_t wr_reg_q;
   logic osc_enable_q;
   logic output_invert_q;
   logic pulse_freq_select_q;
   logic [2:0] pulse_width_code_q;
   paoc_word20_t phase_accum_q;
   paoc_word20_t phase_accum_d;
   paoc_word20_t step_value_q;
   paoc_word20_t step_shadow_q;
   logic src_prev_q;
   logic load_evt_q;
   logic load_sync1_q;
   logic load_sync2_q;
   logic load_sync2_prev_q;
   logic load_pend_q;
   logic out_raw_q;
   logic [6:0] pulse_cnt_q;
   logic wrap_irq_flag_q;
   logic wrap_mask_q;
   logic osc_out_q;
   logic irq_q;
   logic hreadyout_q;
   logic hresp_q;

   // ========================================================================
   // helpers
   // byte lane of a 20-bit value, bits above bit 19 read as zero
   function automatic logic [7:0] byte_of(input paoc_word20_t v, input logic [1:0] idx);
      logic [23:0] w;
      w = {4'h0, v};
      byte_of = w[idx*8 +: 8];
   endfunction

   // replace one byte lane of a 20-bit value
   function automatic paoc_word20_t put_byte(input paoc_word20_t v, input logic [1:0] idx,
                                             input logic [7:0] b);
      logic [23:0] w;
      w = {4'h0, v};
      w[idx*8 +: 8] = b;
      put_byte = w[19:0];
   endfunction

   // address to register
   function automatic paoc_reg_t decode(input logic [7:0] a);
      case (a)
         `PAOC_ADDR_CTRL: decode = PAOC_R_CTRL;
         `PAOC_ADDR_PULSE: decode = PAOC_R_PULSE;
         `PAOC_ADDR_ACCL: decode = PAOC_R_ACCL;
         `PAOC_ADDR_ACCH: decode = PAOC_R_ACCH;
         `PAOC_ADDR_ACCU: decode = PAOC_R_ACCU;
         `PAOC_ADDR_INCL: decode = PAOC_R_INCL;
         `PAOC_ADDR_INCH: decode = PAOC_R_INCH;
         `PAOC_ADDR_INCU: decode = PAOC_R_INCU;
         `PAOC_ADDR_STATUS: decode = PAOC_R_STATUS;
         `PAOC_ADDR_MASK: decode = PAOC_R_MASK;
         default: decode = PAOC_R_NONE;
      endcase
   endfunction

   // ========================================================================
   // bus decode
   wire logic addr_ok = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);
   wire logic take = hsel && htrans[1] && hready;
   wire paoc_reg_t addr_reg = addr_ok ? decode(haddr[7:0]) : PAOC_R_NONE;
   wire logic rd_take = take && !hwrite;
   wire logic wr_take = take && hwrite;
   wire logic [7:0] wbyte = hwdata[7:0];
   wire logic do_wr = wr_pend_q;
   wire logic wr_ctrl = do_wr && (wr_reg_q == PAOC_R_CTRL);
   wire logic wr_pulse = do_wr && (wr_reg_q == PAOC_R_PULSE);
   wire logic wr_accl = do_wr && (wr_reg_q == PAOC_R_ACCL);
   wire logic wr_acch = do_wr && (wr_reg_q == PAOC_R_ACCH);
   wire logic wr_accu = do_wr && (wr_reg_q == PAOC_R_ACCU);
   wire logic wr_incl = do_wr && (wr_reg_q == PAOC_R_INCL);
   wire logic wr_inch = do_wr && (wr_reg_q == PAOC_R_INCH);
   wire logic wr_incu = do_wr && (wr_reg_q == PAOC_R_INCU);
   wire logic wr_status = do_wr && (wr_reg_q == PAOC_R_STATUS);
   wire logic wr_mask = do_wr && (wr_reg_q == PAOC_R_MASK);
   wire logic wr_acc_any = wr_accl || wr_acch || wr_accu;
   wire logic wr_inc_any = wr_incl || wr_inch || wr_incu;
   wire logic [1:0] acc_lane = wr_accl ? 2'h0 : (wr_acch ? 2'h1 : 2'h2);
   wire logic [1:0] inc_lane = wr_incl ? 2'h0 : (wr_inch ? 2'h1 : 2'h2);
   wire logic [7:0] acc_wbyte = wr_accu ? {4'h0, wbyte[3:0]} : wbyte;
   wire logic [7:0] inc_wbyte = wr_incu ? {4'h0, wbyte[3:0]} : wbyte;

   // read data mux, sampled in the address phase
   wire logic [7:0] ctrl_rd = {osc_enable_q, 1'b0, osc_out_q, output_invert_q, 3'h0, pulse_freq_select_q};
   logic [7:0] rd_byte;
   always_comb begin
      case (addr_reg)
         PAOC_R_CTRL: rd_byte = ctrl_rd;
         PAOC_R_PULSE: rd_byte = {pulse_width_code_q, 5'h00};
         PAOC_R_ACCL: rd_byte = byte_of(phase_accum_q, 2'h0);
         PAOC_R_ACCH: rd_byte = byte_of(phase_accum_q, 2'h1);
         PAOC_R_ACCU: rd_byte = byte_of(phase_accum_q, 2'h2);
         PAOC_R_INCL: rd_byte = byte_of(step_value_q, 2'h0);
         PAOC_R_INCH: rd_byte = byte_of(step_value_q, 2'h1);
         PAOC_R_INCU: rd_byte = byte_of(step_value_q, 2'h2);
         PAOC_R_STATUS: rd_byte = {7'h00, wrap_irq_flag_q};
         PAOC_R_MASK: rd_byte = {7'h00, wrap_mask_q};
         default: rd_byte = 8'h00;
      endcase
   end

   // ========================================================================
   // source clock edges, the source is sampled as a synchronous input
   wire logic src_rise = osc_src_clock && !src_prev_q;
   wire logic src_fall = !osc_src_clock && src_prev_q;
   wire logic tick = osc_enable_q && src_rise;
   wire logic [20:0] sum = {1'b0, phase_accum_q} + {1'b0, step_shadow_q};
   wire logic accum_wrap = tick && sum[20];
   wire logic load_sync_evt = load_sync2_q && !load_sync2_prev_q;
   wire logic [6:0] pulse_len = 7'(({7'h00, 1'b1} << pulse_width_code_q) - 8'h01);
   // write-one clear of the wrap flag
   wire logic wrap_clr = wr_status && wbyte[`PAOC_WRAP_BIT];
   // flag value after this edge, so irq follows the flag with no extra lag
   wire logic flag_d = accum_wrap || (wrap_irq_flag_q && !wrap_clr);

   // accumulator next value, a bus write wins over the adder
   always_comb begin
      phase_accum_d = phase_accum_q;
      if (tick) begin
         phase_accum_d = sum[19:0];
      end
      if (wr_acc_any) begin
         phase_accum_d = put_byte(phase_accum_q, acc_lane, acc_wbyte);
      end
   end

   // ========================================================================
   // bus slave registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata_q <= 32'h00000000;
         wr_pend_q <= 1'b0;
         wr_reg_q <= PAOC_R_NONE;
      end else begin
         wr_pend_q <= wr_take;
         wr_reg_q <= addr_reg;
         if (rd_take) begin
            hrdata_q <= {24'h000000, rd_byte};
         end
      end
   end

   // control and mask registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_enable_q <= 1'b0;
         output_invert_q <= 1'b0;
         pulse_freq_select_q <= 1'b0;
         pulse_width_code_q <= 3'h0;
         wrap_mask_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            osc_enable_q <= wbyte[`PAOC_CTRL_EN_BIT];
            output_invert_q <= wbyte[`PAOC_CTRL_POL_BIT];
            pulse_freq_select_q <= wbyte[`PAOC_CTRL_PFM_BIT];
         end
         if (wr_pulse) begin
            pulse_width_code_q <= wbyte[`PAOC_PWS_MSB:`PAOC_PWS_LSB];
         end
         if (wr_mask) begin
            wrap_mask_q <= wbyte[`PAOC_WRAP_BIT];
         end
      end
   end

   // accumulator and visible step
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_accum_q <= `PAOC_ACC_RESET;
         step_value_q <= `PAOC_STEP_RESET;
      end else begin
         phase_accum_q <= phase_accum_d;
         if (wr_inc_any) begin
            step_value_q <= put_byte(step_value_q, inc_lane, inc_wbyte);
         end
      end
   end

   // low step write event through a two-stage synchroniser
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         load_evt_q <= 1'b0;
         load_sync1_q <= 1'b0;
         load_sync2_q <= 1'b0;
         load_sync2_prev_q <= 1'b0;
      end else begin
         if (wr_incl) begin
            load_evt_q <= !load_evt_q;
         end
         load_sync1_q <= load_evt_q;
         load_sync2_q <= load_sync1_q;
         load_sync2_prev_q <= load_sync2_q;
      end
   end

   // shadow step, loaded on the falling source edge after every second low write
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         step_shadow_q <= `PAOC_STEP_RESET;
         load_pend_q <= 1'b0;
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= osc_src_clock;
         if (!osc_enable_q) begin
            step_shadow_q <= step_value_q; // disabled: follows at once
            load_pend_q <= 1'b0;
         end else if (load_sync_evt) begin
            load_pend_q <= 1'b1;
         end else if (load_pend_q && src_fall) begin
            step_shadow_q <= step_value_q;
            load_pend_q <= 1'b0;
         end
      end
   end

   // output shaping
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_raw_q <= 1'b0;
         pulse_cnt_q <= 7'h00;
      end else if (!pulse_freq_select_q) begin
         pulse_cnt_q <= 7'h00;
         if (accum_wrap) begin
            out_raw_q <= !out_raw_q;
         end
      end else if (accum_wrap) begin
         out_raw_q <= 1'b1;
         pulse_cnt_q <= pulse_len;
      end else if (tick && out_raw_q) begin
         if (pulse_cnt_q == 7'h00) begin
            out_raw_q <= 1'b0;
         end else begin
            pulse_cnt_q <= pulse_cnt_q - 7'h01;
         end
      end
   end

   // interrupt flag, set wins over a write-one clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrap_irq_flag_q <= 1'b0;
         osc_out_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (accum_wrap) begin
            wrap_irq_flag_q <= 1'b1;
         end else if (wrap_clr) begin
            wrap_irq_flag_q <= 1'b0;
         end
         osc_out_q <= out_raw_q ^ output_invert_q;
         irq_q <= flag_d && wrap_mask_q;
      end
   end

   // bus handshake flops, zero wait states and always okay
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // ========================================================================
   // outputs
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign osc_out = osc_out_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// File: paoc_core_checker.sv
// port assertions for the phase accumulator oscillator core
`include "paoc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module paoc_core_checker (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic osc_src_clock,
   input wire logic osc_out,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // bus decode helpers
   wire rd_req = hsel && htrans[1] && !hwrite && hready;
   wire nib_req = rd_req && (haddr == `PAOC_ADDR_ACCU || haddr == `PAOC_ADDR_INCU);
   // no bus request and a still source clock
   sequence s_quiet;
      (!(hsel && htrans[1]) && $stable(osc_src_clock)) [*8];
   endsequence
   // ==========================================================
   // assertions
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_rdata_byte_only: assert property (hrdata[31:8] == 24'h0)
      else $error("hrdata upper bits set");
   a_nibble_top_zero: assert property (nib_req |=> hrdata[7:4] == 4'h0)
      else $error("upper nibble register bits 7:4 set");
   a_unmapped_zero: assert property (rd_req && haddr > 32'h24 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!rd_req |=> $stable(hrdata))
      else $error("hrdata changed without read");
   a_out_quiet: assert property (s_quiet |-> $stable(osc_out))
      else $error("osc_out moved without cause");
   a_irq_quiet: assert property (s_quiet |-> $stable(irq))
      else $error("irq moved without cause");
endmodule
bind paoc_core paoc_core_checker u_chk (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hrdata, .hreadyout, .hresp, .osc_src_clock, .osc_out, .irq);
`default_nettype wire

// File: paoc_core_tb.sv
// self-checking bench for the phase accumulator oscillator core
`include "paoc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module paoc_core_tb;
   logic sys_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, osc_src_clock = 0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hready, hreadyout, hresp, osc_out, irq;
   int err_total = 0, checks = 0;
   logic [7:0] ra [6] = '{`PAOC_ADDR_ACCL, `PAOC_ADDR_ACCH, `PAOC_ADDR_ACCU,
      `PAOC_ADDR_INCL, `PAOC_ADDR_INCH, `PAOC_ADDR_INCU};
   logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
   logic [7:0] wd [6] = '{8'hA5, 8'h3C, 8'hFF, 8'h5A, 8'hC3, 8'hF7};
   logic [7:0] we [6] = '{8'hA5, 8'h3C, 8'h0F, 8'h5A, 8'hC3, 8'h07};
   // ==========================================================
   // clock and design
   always #2.5 sys_clk = ~sys_clk;
   assign hready = hreadyout;
   paoc_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .osc_src_clock(osc_src_clock), .osc_out(osc_out), .irq(irq));
   // ==========================================================
   // verdict and end of run
   task automatic report_and_stop();
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // wait for hready at a rising edge, bounded
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         err_total++;
         report_and_stop();
      end
   endtask
   // one single word transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, rd);
   endtask
   task automatic rcheck(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00, rd);
      chk(rd, {24'h0, e});
   endtask
   // one full period of the oscillator source
   task automatic tick();
      @(posedge sys_clk) osc_src_clock <= 1'b1;
      repeat (8) @(posedge sys_clk);
      osc_src_clock <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rcheck(ra[i], rv[i]);
      // core disabled, so accumulator writes are legal
      for (int i = 0; i < 6; i++) begin
         wr(ra[i], wd[i]);
         rcheck(ra[i], we[i]);
      end
      rcheck(8'h40, 8'h00);
      wr(`PAOC_ADDR_INCU, 8'h08);
      wr(`PAOC_ADDR_INCH, 8'h00);
      wr(`PAOC_ADDR_INCL, 8'h00);
      for (int i = 0; i < 3; i++) wr(ra[i], 8'h00);
      wr(`PAOC_ADDR_MASK, 8'h01);
      wr(`PAOC_ADDR_CTRL, 8'h80);
      tick();
      rcheck(`PAOC_ADDR_ACCU, 8'h08);
      chk(irq, 1'b0);
      tick();
      rcheck(`PAOC_ADDR_ACCU, 8'h00);
      rcheck(`PAOC_ADDR_STATUS, 8'h01);
      chk(irq, 1'b1);
      rcheck(`PAOC_ADDR_CTRL, 8'hA0);
      wr(`PAOC_ADDR_STATUS, 8'h01);
      rcheck(`PAOC_ADDR_STATUS, 8'h00);
      chk(irq, 1'b0);
      // new step while running: next rise still uses the old shadow
      wr(`PAOC_ADDR_INCU, 8'h00);
      wr(`PAOC_ADDR_INCH, 8'h00);
      wr(`PAOC_ADDR_INCL, 8'h10);
      tick();
      tick();
      rcheck(`PAOC_ADDR_ACCU, 8'h08);
      rcheck(`PAOC_ADDR_ACCL, 8'h10);
      chk(osc_out, 1'b1);
      // mid-run reset brings every register back
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      chk(osc_out, 1'b0);
      chk(irq, 1'b0);
      for (int i = 0; i < 6; i++) rcheck(ra[i], rv[i]);
      rcheck(`PAOC_ADDR_CTRL, 8'h00);
      // pulse frequency mode, width code 1, inverted output, interrupt masked off
      wr(`PAOC_ADDR_INCU, 8'h04);
      wr(`PAOC_ADDR_INCH, 8'h00);
      wr(`PAOC_ADDR_INCL, 8'h00);
      wr(`PAOC_ADDR_PULSE, 8'h20);
      rcheck(`PAOC_ADDR_PULSE, 8'h20);
      wr(`PAOC_ADDR_CTRL, 8'h91);
      repeat (3) tick();
      chk(osc_out, 1'b1);
      tick();
      chk(osc_out, 1'b0);
      tick();
      chk(osc_out, 1'b0);
      tick();
      chk(osc_out, 1'b1);
      rcheck(`PAOC_ADDR_CTRL, 8'hB1);
      rcheck(`PAOC_ADDR_STATUS, 8'h01);
      chk(irq, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
